// >>> core/pci_top.sv
// Operation
// - rising enable sets pin flag on rise
// - falling enable sets pin flag on fall
// - disabled direction never sets pin flag
// - any pin flag set by an enabled edge raises port flag; a software write to the flags does not
// - pin flags sticky until software writes zero
// - only bits five to zero implemented
// - all enables and flags reset zero
// - both enables flag either direction
module pci_top #(
    parameter int NPINS = pci_pkg::NUM_PINS
) (
    // clock and reset
    input  wire logic             REF_CLK,
    input  wire logic             SYS_RST,
    // apb slave
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [7:0]       PADDR,
    input  wire logic [31:0]      PWDATA,
    input  wire logic [3:0]       PSTRB,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    // port pins
    input  wire logic [NPINS-1:0] PORT_A_PIN,
    // interrupt
    output logic                  IRQ
);
    pci_pkg::pci_apb_req_t req;
    pci_pkg::pci_apb_state_t state_r;
    pci_pkg::pci_apb_state_t state_nxt;

    logic [NPINS-1:0] pin_sync;
    logic [NPINS-1:0] rise;
    logic [NPINS-1:0] fall;
    logic [NPINS-1:0] rise_en_r;
    logic [NPINS-1:0] fall_en_r;
    logic [NPINS-1:0] flags_r;
    logic [NPINS-1:0] flags_nxt;
    logic [NPINS-1:0] hit;
    logic             port_flag_r;
    logic             port_flag_nxt;
    logic             port_mask_r;
    logic             wr_stb;
    logic             rd_stb;
    logic             lane0;

    always_comb
    begin
        req.sel    = PSEL;
        req.enable = PENABLE;
        req.write  = PWRITE;
        req.addr   = PADDR;
        req.wdata  = PWDATA;
    end

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == pci_pkg::RISE_EN_OFS) || (a == pci_pkg::FALL_EN_OFS) ||
                    (a == pci_pkg::FLAGS_OFS) || (a == pci_pkg::IRQ_STAT_OFS) ||
                    (a == pci_pkg::IRQ_MASK_OFS);
    endfunction

    pci_sync #(
        .WIDTH (NPINS)
    ) u_sync (
        .clk (REF_CLK),
        .rst (SYS_RST),
        .d   (PORT_A_PIN),
        .q   (pin_sync)
    );

    pci_edge #(
        .WIDTH (NPINS)
    ) u_edge (
        .clk   (REF_CLK),
        .rst   (SYS_RST),
        .level (pin_sync),
        .rise  (rise),
        .fall  (fall)
    );

    // apb: one wait state, so every access is answered in its second access cycle
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            pci_pkg::ST_IDLE:
                if (req.sel && !req.enable)
                    state_nxt = pci_pkg::ST_ACCESS;
            pci_pkg::ST_ACCESS:
                state_nxt = pci_pkg::ST_DONE;
            pci_pkg::ST_DONE:
                state_nxt = pci_pkg::ST_IDLE;
            default:
                state_nxt = pci_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            state_r <= pci_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_comb
    begin
        wr_stb = (state_r == pci_pkg::ST_ACCESS) && req.sel && req.enable && req.write;
        rd_stb = (state_r == pci_pkg::ST_ACCESS) && req.sel && req.enable && !req.write;
        lane0  = PSTRB[0];
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end
        else if (state_r == pci_pkg::ST_ACCESS)
        begin
            PREADY  <= 1'b1;
            PSLVERR <= !is_mapped(req.addr);
            PRDATA  <= 32'h0000_0000;
            if (rd_stb)
            begin
                // upper bits of every register read as zero
                case (req.addr)
                    pci_pkg::RISE_EN_OFS:  PRDATA[NPINS-1:0] <= rise_en_r;
                    pci_pkg::FALL_EN_OFS:  PRDATA[NPINS-1:0] <= fall_en_r;
                    pci_pkg::FLAGS_OFS:    PRDATA[NPINS-1:0] <= flags_r;
                    pci_pkg::IRQ_STAT_OFS: PRDATA[0]         <= port_flag_r;
                    pci_pkg::IRQ_MASK_OFS: PRDATA[0]         <= port_mask_r;
                    default:               PRDATA            <= 32'h0000_0000;
                endcase
            end
        end
        else
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // enable registers
    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            rise_en_r   <= pci_pkg::PIN_REG_RST;
            fall_en_r   <= pci_pkg::PIN_REG_RST;
            port_mask_r <= pci_pkg::IRQ_REG_RST;
        end
        else if (wr_stb && lane0)
        begin
            if (req.addr == pci_pkg::RISE_EN_OFS)
                rise_en_r <= req.wdata[NPINS-1:0];
            if (req.addr == pci_pkg::FALL_EN_OFS)
                fall_en_r <= req.wdata[NPINS-1:0];
            if (req.addr == pci_pkg::IRQ_MASK_OFS)
                port_mask_r <= req.wdata[pci_pkg::STAT_PORT_CHG_BIT];
        end
    end

    // edge qualification: a pin can carry either enable alone or both
    always_comb
    begin
        hit = (rise & rise_en_r) | (fall & fall_en_r);
    end

    // pin flags: software writes the value, a hardware hit in the same cycle wins
    always_comb
    begin
        flags_nxt = flags_r;
        if (wr_stb && lane0 && req.addr == pci_pkg::FLAGS_OFS)
            flags_nxt = req.wdata[NPINS-1:0];
        flags_nxt = flags_nxt | hit;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
            flags_r <= pci_pkg::PIN_REG_RST;
        else
            flags_r <= flags_nxt;
    end

    // port flag: write one to clear, set on any hit, set wins over clear
    always_comb
    begin
        port_flag_nxt = port_flag_r;
        if (wr_stb && lane0 && req.addr == pci_pkg::IRQ_STAT_OFS &&
            req.wdata[pci_pkg::STAT_PORT_CHG_BIT])
            port_flag_nxt = 1'b0;
        if (|hit)
            port_flag_nxt = 1'b1;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            port_flag_r <= pci_pkg::IRQ_REG_RST;
            IRQ         <= 1'b0;
        end
        else
        begin
            port_flag_r <= port_flag_nxt;
            // registered output: one cycle behind the flag
            IRQ         <= port_flag_r & port_mask_r;
        end
    end

    // assertions
    AST_RISE_SETS: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (rise[0] && rise_en_r[0]) |=> flags_r[0])
        else $error("enabled rise did not set flag");
    AST_FALL_SETS: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (fall[0] && fall_en_r[0]) |=> flags_r[0])
        else $error("enabled fall did not set flag");
    AST_NO_DISABLED: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (!flags_r[0] && !(rise[0] && rise_en_r[0]) && !(fall[0] && fall_en_r[0]) &&
         !(wr_stb && req.addr == pci_pkg::FLAGS_OFS)) |=> !flags_r[0])
        else $error("flag set without enabled edge");
    AST_PORT_FLAG: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (|hit) |=> port_flag_r)
        else $error("port flag not raised");
    AST_STICKY: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (flags_r[0] && !(wr_stb && req.addr == pci_pkg::FLAGS_OFS)) |=> flags_r[0])
        else $error("pin flag dropped without write");
    AST_UPPER_ZERO: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        $rose(PREADY) && (PADDR == pci_pkg::FLAGS_OFS) |-> PRDATA[31:NPINS] == '0)
        else $error("unimplemented bits read nonzero");
    AST_RESET_ZERO: assert property (@(posedge REF_CLK)
        SYS_RST |=> (flags_r == '0 && rise_en_r == '0 && fall_en_r == '0 &&
                     !port_flag_r && !port_mask_r && !IRQ && !PREADY))
        else $error("registers not zero after reset");
    AST_BOTH_EDGES: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (rise_en_r[1] && fall_en_r[1] && (rise[1] || fall[1])) |=> flags_r[1])
        else $error("dual enable missed an edge");
    AST_SYNC_EDGE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        rise[0] |-> (pin_sync[0] && $past(pin_sync[0]) == 1'b0))
        else $error("rise without sampled transition");
    AST_IRQ: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        ##1 (IRQ == $past(port_flag_r && port_mask_r)))
        else $error("irq does not follow flag and mask");
    AST_RISE_ALL: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        ((rise & rise_en_r) != '0) |=> ((flags_r & $past(rise & rise_en_r)) == $past(rise & rise_en_r)))
        else $error("enabled rise left a pin flag clear");
    AST_FALL_ALL: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        ((fall & fall_en_r) != '0) |=> ((flags_r & $past(fall & fall_en_r)) == $past(fall & fall_en_r)))
        else $error("enabled fall left a pin flag clear");
    AST_NO_SPURIOUS: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !(wr_stb && lane0 && req.addr == pci_pkg::FLAGS_OFS) |=> ((flags_r & ~$past(flags_r | hit)) == '0))
        else $error("pin flag set without an enabled edge");
    AST_PORT_STICKY: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (port_flag_r && !(wr_stb && req.addr == pci_pkg::IRQ_STAT_OFS)) |=> port_flag_r)
        else $error("port flag dropped without a clear");
    AST_PORT_ONLY_HIT: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (!port_flag_r && !(|hit)) |=> !port_flag_r)
        else $error("port flag set without an enabled edge");
    AST_FLAG_WRITE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (wr_stb && lane0 && req.addr == pci_pkg::FLAGS_OFS) |=> (flags_r == $past(req.wdata[NPINS-1:0] | hit)))
        else $error("pin flag write not applied");
    AST_UPPER_ZERO_RISE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        $rose(PREADY) && (PADDR == pci_pkg::RISE_EN_OFS) |-> PRDATA[31:NPINS] == '0)
        else $error("unimplemented rise enable bits read nonzero");
    AST_UPPER_ZERO_FALL: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        $rose(PREADY) && (PADDR == pci_pkg::FALL_EN_OFS) |-> PRDATA[31:NPINS] == '0)
        else $error("unimplemented fall enable bits read nonzero");
    AST_SYNC_FALL: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        fall[0] |-> (!pin_sync[0] && $past(pin_sync[0]) == 1'b1))
        else $error("fall without sampled transition");
    AST_IRQ_SET: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (port_flag_r && port_mask_r) |=> IRQ)
        else $error("irq missing while flag and mask set");
    AST_IRQ_MASKED: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !port_mask_r |=> !IRQ)
        else $error("irq raised while masked");
    // bus answer: one wait state, ready for one cycle, error only with ready
    AST_READY_ANSWER: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        (state_r == pci_pkg::ST_IDLE && PSEL && !PENABLE) |-> ##2 PREADY)
        else $error("access not answered after one wait state");
    AST_READY_PULSE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        PREADY |=> !PREADY)
        else $error("ready held for more than one cycle");
    AST_ERR_WITH_READY: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        PSLVERR |-> PREADY)
        else $error("error response without ready");
    AST_UNMAPPED_ERR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        ($rose(PREADY) && !is_mapped(PADDR)) |-> PSLVERR)
        else $error("unmapped access answered without error");
    AST_MAPPED_OK: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        ($rose(PREADY) && is_mapped(PADDR)) |-> !PSLVERR)
        else $error("mapped access answered with error");
endmodule

// >>> core/pci_pkg.sv
package pci_pkg;
    // register byte addresses on the APB bus
    localparam logic [7:0] RISE_EN_OFS  = 8'h00;
    localparam logic [7:0] FALL_EN_OFS  = 8'h04;
    localparam logic [7:0] FLAGS_OFS    = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
    // field layout
    localparam int PIN_LSB  = 0;
    localparam int PIN_MSB  = 5;
    localparam int NUM_PINS = 6;
    localparam int STAT_PORT_CHG_BIT = 0;
    // reset values
    localparam logic [5:0] PIN_REG_RST = 6'h00;
    localparam logic [0:0] IRQ_REG_RST = 1'h0;

    typedef struct packed {
        logic       sel;
        logic       enable;
        logic       write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } pci_apb_req_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACCESS = 3'b010,
        ST_DONE   = 3'b100
    } pci_apb_state_t;
endpackage

// >>> core/pci_sync.sv
module pci_sync #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// >>> core/pci_edge.sv
module pci_edge #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // synchronised level in, edge pulses out
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_r;

    // the synchroniser is cleared by reset too, so edges are held off until both
    // of its stages and the previous sample carry real pin levels; a pin already
    // high at release then gives no rising edge
    logic [2:0] seeded_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_r   <= '0;
            seeded_r <= 3'h0;
        end
        else
        begin
            prev_r   <= level;
            seeded_r <= {seeded_r[1:0], 1'b1};
        end
    end

    always_comb
    begin
        rise = seeded_r[2] ? (level & ~prev_r) : '0;
        fall = seeded_r[2] ? (~level & prev_r) : '0;
    end
endmodule

// >>> test/pci_pin_drv.sv
// stands in for the pads outside the port: levels change just after an edge
module pci_pin_drv (
    // clock
    input  wire logic       clk,
    // level asked for by the bench
    input  wire logic [5:0] lvl,
    // port pins
    output logic      [5:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pins = 6'h00;

    // pads are always driven, so no released level is modelled
    always @(posedge clk)
    begin
        pins <= lvl;
    end
endmodule

// >>> test/pin_change_interrupt_unit_tb.sv
module pin_change_interrupt_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [5:0] re;
        logic [5:0] fe;
        logic [5:0] lo;
        logic [5:0] hi;
        logic [5:0] ex;
    } pci_row_t;

    logic        REF_CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        PSEL    = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE  = 1'b0;
    logic [7:0]  PADDR   = 8'h00;
    logic [31:0] PWDATA  = 32'h0;
    logic [3:0]  PSTRB   = 4'hF;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic [5:0]  PORT_A_PIN;
    logic [5:0]  pin_lvl = 6'h00;
    logic        IRQ;
    logic [31:0] q;
    logic        e;
    int          n_errors = 0;
    int          samples_checked = 0;
    pci_row_t    rows [7] = '{'{6'h3F, 6'h00, 6'h00, 6'h3F, 6'h3F}, '{6'h3F, 6'h00, 6'h3F, 6'h00, 6'h00},
                              '{6'h00, 6'h3F, 6'h3F, 6'h00, 6'h3F}, '{6'h00, 6'h3F, 6'h00, 6'h3F, 6'h00},
                              '{6'h3F, 6'h3F, 6'h15, 6'h2A, 6'h3F}, '{6'h0F, 6'h00, 6'h00, 6'h3F, 6'h0F},
                              '{6'h00, 6'h30, 6'h3F, 6'h00, 6'h30}};

    always #5 REF_CLK = ~REF_CLK;

    pci_top i_pci_top (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PORT_A_PIN(PORT_A_PIN), .IRQ(IRQ));
    pci_pin_drv i_pci_pin_drv (.clk(REF_CLK), .lvl(pin_lvl), .pins(PORT_A_PIN));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        // the slave decides the wait; only the watchdog ends it
        while (PREADY !== 1'b1)
        begin
            @(posedge REF_CLK);
        end
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask

    task automatic pins(input logic [5:0] v);
        @(posedge REF_CLK);
        pin_lvl <= v;
        idle(6);
    endtask

    task automatic do_reset;
        @(posedge REF_CLK);
        SYS_RST <= 1'b1;
        idle(10);
        SYS_RST <= 1'b0;
        rd(pci_pkg::RISE_EN_OFS, 32'h0, "rise_rst");
        rd(pci_pkg::FALL_EN_OFS, 32'h0, "fall_rst");
        rd(pci_pkg::FLAGS_OFS, 32'h0, "flags_rst");
        rd(pci_pkg::IRQ_STAT_OFS, 32'h0, "stat_rst");
        rd(pci_pkg::IRQ_MASK_OFS, 32'h0, "mask_rst");
        chk("irq_rst", {31'h0, IRQ}, 32'h0);
        $display("test reset done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        n_errors++;
        conclude();
    end

    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            // enables off while the start level settles, so it leaves no flag
            wr(pci_pkg::RISE_EN_OFS, 32'h0);
            wr(pci_pkg::FALL_EN_OFS, 32'h0);
            pins(rows[i].lo);
            wr(pci_pkg::FLAGS_OFS, 32'h0);
            wr(pci_pkg::IRQ_STAT_OFS, 32'h1);
            wr(pci_pkg::RISE_EN_OFS, {26'h0, rows[i].re});
            wr(pci_pkg::FALL_EN_OFS, {26'h0, rows[i].fe});
            pins(rows[i].hi);
            rd(pci_pkg::FLAGS_OFS, {26'h0, rows[i].ex}, "flags");
            rd(pci_pkg::IRQ_STAT_OFS, {31'h0, |rows[i].ex}, "port_flag");
        end
        $display("test edge table done");
        wr(pci_pkg::RISE_EN_OFS, 32'h1);
        wr(pci_pkg::FLAGS_OFS, 32'h0);
        pins(6'h01);
        pins(6'h00);
        rd(pci_pkg::FLAGS_OFS, 32'h1, "sticky");
        wr(pci_pkg::FLAGS_OFS, 32'h0);
        rd(pci_pkg::FLAGS_OFS, 32'h0, "sw_clear");
        wr(pci_pkg::RISE_EN_OFS, 32'hFFFFFFFF);
        rd(pci_pkg::RISE_EN_OFS, 32'h3F, "rise_upper");
        wr(pci_pkg::FALL_EN_OFS, 32'hFFFFFFC0);
        rd(pci_pkg::FALL_EN_OFS, 32'h0, "fall_upper");
        // a write with its low lane strobe off must leave the register alone
        PSTRB <= 4'h0;
        wr(pci_pkg::RISE_EN_OFS, 32'h0);
        PSTRB <= 4'hF;
        rd(pci_pkg::RISE_EN_OFS, 32'h3F, "strobe_off");
        $display("test sticky and width done");
        wr(pci_pkg::IRQ_MASK_OFS, 32'h1);
        idle(2);
        chk("irq_on", {31'h0, IRQ}, 32'h1);
        wr(pci_pkg::IRQ_MASK_OFS, 32'h0);
        idle(2);
        chk("irq_masked", {31'h0, IRQ}, 32'h0);
        wr(pci_pkg::IRQ_STAT_OFS, 32'h1);
        wr(pci_pkg::IRQ_MASK_OFS, 32'h1);
        idle(2);
        chk("irq_cleared", {31'h0, IRQ}, 32'h0);
        pins(6'h3F);
        chk("irq_edge", {31'h0, IRQ}, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        chk("unmapped_data", q, 32'h0);
        $display("test irq and unmapped done");
        // state is non-zero here apart from the fall enables, so the second reset proves the other registers clear
        do_reset();
        conclude();
    end
endmodule
